// ### logic/timer_pkg.sv
package timer_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// ****************************************************************
	// Register byte addresses
	// ****************************************************************
	localparam logic [7:0] CLOCK_SELECT_ADDR  = 8'h00;
	localparam logic [7:0] CONTROL_ADDR       = 8'h04;
	localparam logic [7:0] LIMIT_CONTROL_ADDR = 8'h08;
	localparam logic [7:0] RESET_SOURCE_ADDR  = 8'h0C;
	localparam logic [7:0] PERIOD_ADDR        = 8'h10;
	localparam logic [7:0] COUNT_ADDR         = 8'h14;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int unsigned ON_BIT     = 7;
	localparam int unsigned PRESCALER_SYNC_ENABLE_BIT  = 7;
	localparam int unsigned CLOCK_POLARITY_SELECT_BIT  = 6;
	localparam int unsigned ENABLE_SYNC_TO_CLOCK_BIT = 5;
	localparam logic [7:0]  REG_RESET  = 8'h00;

	// ****************************************************************
	// Clock source and mode codes
	// ****************************************************************
	localparam logic [3:0] CS_INSTR_CLK = 4'h1;
	localparam logic [3:0] CS_SYS_CLK   = 4'h2;
	localparam logic [3:0] CS_HF_OSC    = 4'h3;
	localparam logic [3:0] CS_LF_OSC    = 4'h4;
	localparam logic [3:0] CS_MF_OSC    = 4'h5;
	localparam logic [3:0] CS_LAST      = 4'hA;
	localparam logic [4:0] RSEL_LAST    = 5'h11;
	localparam int unsigned CLK_SRC_N   = 11;
	localparam int unsigned RST_SRC_N   = 18;
	localparam logic [4:0] MODE_LVL_OS_LOW  = 5'h16;
	localparam logic [4:0] MODE_LVL_OS_HIGH = 5'h17;
	localparam logic [1:0] INSTR_DIV_LAST   = 2'h3;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} apb_req_s;

endpackage

// ### logic/hw_limit_period_timer.sv
// Our own choices: the register offsets and the APB register port.
module hw_limit_period_timer
#(
	parameter int unsigned COUNT_W = 8
)
(
	input  wire logic                               pclk,
	input  wire logic                               presetn,
	input  wire timer_pkg::apb_req_s                apb_req,
	output logic [timer_pkg::DATA_W-1:0]            prdata,
	output logic                                    pready,
	output logic                                    pslverr,
	input  wire logic [timer_pkg::CLK_SRC_N-1:0]    clock_sources,
	input  wire logic [timer_pkg::RST_SRC_N-1:0]    reset_sources,
	input  wire logic                               sleep_active,
	output logic [COUNT_W-1:0]                      count_value,
	output logic                                    pwm_start_pulse,
	output logic                                    postscaled_pulse,
	output logic [2:0]                              osc_keep_running
);
	import timer_pkg::*;

	if (COUNT_W != 8)
	begin : width_check
		$error("Only an 8-bit count is supported");
	end

	function automatic logic is_level_oneshot(input logic [4:0] m);
		is_level_oneshot = (m == MODE_LVL_OS_LOW) || (m == MODE_LVL_OS_HIGH);
	endfunction

	function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] r);
		addr_is = (a == r);
	endfunction

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [3:0]         clock_select_reg;
	logic               on_reg;
	logic [2:0]         prescale_field;
	logic [3:0]         postscale_field;
	logic [7:0]         limit_control_reg;
	logic [4:0]         reset_source_field;
	logic [7:0]         period_register;
	logic [7:0]         period_buffer_reg;
	logic [7:0]         count_register;
	logic               ready_reg;
	logic               slverr_reg;
	logic [DATA_W-1:0]  rdata_reg;
	logic [1:0]         instr_div_reg;
	logic               clk_level_prev_reg;
	logic [1:0]         on_sync_reg;
	logic [6:0]         prescale_count_reg;
	logic               prescale_pending_reg;
	logic [3:0]         postscale_count_reg;
	logic               run_prev_reg;
	logic               held_prev_reg;

	logic       prescaler_sync_enable;
	logic       clock_polarity_select;
	logic       enable_sync_to_clock;
	logic [4:0] mode_field;
	assign prescaler_sync_enable = limit_control_reg[PRESCALER_SYNC_ENABLE_BIT];
	assign clock_polarity_select = limit_control_reg[CLOCK_POLARITY_SELECT_BIT];
	assign enable_sync_to_clock  = limit_control_reg[ENABLE_SYNC_TO_CLOCK_BIT];
	assign mode_field            = limit_control_reg[4:0];

	// ****************************************************************
	// APB slave
	// ****************************************************************
	logic setup_phase;
	logic wr_done;
	logic addr_known;
	assign setup_phase = apb_req.psel && !apb_req.penable;
	assign wr_done     = apb_req.psel && apb_req.penable && ready_reg && apb_req.pwrite && !slverr_reg;
	assign addr_known  = addr_is(apb_req.paddr, CLOCK_SELECT_ADDR) || addr_is(apb_req.paddr, CONTROL_ADDR)
		|| addr_is(apb_req.paddr, LIMIT_CONTROL_ADDR) || addr_is(apb_req.paddr, RESET_SOURCE_ADDR)
		|| addr_is(apb_req.paddr, PERIOD_ADDR) || addr_is(apb_req.paddr, COUNT_ADDR);

	logic wr_clock, wr_control, wr_limit, wr_rsel, wr_period, wr_count;
	assign wr_clock   = wr_done && addr_is(apb_req.paddr, CLOCK_SELECT_ADDR);
	assign wr_control = wr_done && addr_is(apb_req.paddr, CONTROL_ADDR);
	assign wr_limit   = wr_done && addr_is(apb_req.paddr, LIMIT_CONTROL_ADDR);
	assign wr_rsel    = wr_done && addr_is(apb_req.paddr, RESET_SOURCE_ADDR);
	assign wr_period  = wr_done && addr_is(apb_req.paddr, PERIOD_ADDR);
	assign wr_count   = wr_done && addr_is(apb_req.paddr, COUNT_ADDR);

	logic [7:0] read_mux;
	always_comb
	begin
		read_mux = REG_RESET;
		case (apb_req.paddr)
			CLOCK_SELECT_ADDR:  read_mux = {4'h0, clock_select_reg};
			CONTROL_ADDR:       read_mux = {on_reg, prescale_field, postscale_field};
			LIMIT_CONTROL_ADDR: read_mux = limit_control_reg;
			RESET_SOURCE_ADDR:  read_mux = {3'h0, reset_source_field};
			PERIOD_ADDR:        read_mux = period_register;
			COUNT_ADDR:         read_mux = count_register;
			default:            read_mux = REG_RESET;
		endcase
	end

	// One wait-free access cycle; answer prepared during setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ready_reg  <= 1'b0;
			slverr_reg <= 1'b0;
			rdata_reg  <= '0;
		end
		else
		begin
			ready_reg  <= setup_phase;
			slverr_reg <= setup_phase && !addr_known;
			if (setup_phase)
				rdata_reg <= {24'h000000, read_mux};
		end
	end
	assign pready  = ready_reg;
	assign pslverr = slverr_reg;
	assign prdata  = rdata_reg;

	// ****************************************************************
	// Timer clock selection and edge detection
	// ****************************************************************
	logic instr_tick;
	logic clk_level;
	logic clk_tick;
	logic ers_level;
	assign instr_tick = (instr_div_reg == INSTR_DIV_LAST) && !sleep_active;
	assign clk_level  = (clock_select_reg <= CS_LAST) ? clock_sources[clock_select_reg] : 1'b0;
	assign ers_level  = (reset_source_field <= RSEL_LAST) ? reset_sources[reset_source_field] : 1'b0;

	// System-derived clocks stop in Sleep; oscillator and pin sources do not
	always_comb
	begin
		case (clock_select_reg)
			CS_INSTR_CLK: clk_tick = instr_tick;
			CS_SYS_CLK:   clk_tick = !sleep_active;
			default:      clk_tick = clock_polarity_select ? (clk_level_prev_reg && !clk_level)
				: (!clk_level_prev_reg && clk_level);
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			instr_div_reg      <= 2'h0;
			clk_level_prev_reg <= 1'b0;
		end
		else
		begin
			instr_div_reg      <= instr_div_reg + 2'h1;
			clk_level_prev_reg <= clk_level;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			osc_keep_running <= 3'h0;
		else
			osc_keep_running <= {clock_select_reg == CS_HF_OSC, clock_select_reg == CS_MF_OSC,
				clock_select_reg == CS_LF_OSC};
	end

	// ****************************************************************
	// Enable, start and stop
	// ****************************************************************
	logic level_mode;
	logic at_reset_level;
	logic on_eff;
	logic run;
	logic frozen;
	assign level_mode     = is_level_oneshot(mode_field);
	assign at_reset_level = level_mode && (ers_level == mode_field[0]);
	assign on_eff         = enable_sync_to_clock ? on_sync_reg[1] : on_reg;
	assign run            = on_eff && !at_reset_level;
	assign frozen         = sleep_active && prescaler_sync_enable;

	// Enable passes through two timer-clock ticks for glitch-free start
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			on_sync_reg <= 2'h0;
		else if (!on_reg)
			on_sync_reg <= 2'h0;
		else if (clk_tick)
			on_sync_reg <= {on_sync_reg[0], on_reg};
	end

	// ****************************************************************
	// Prescaler
	// ****************************************************************
	logic [6:0] prescale_last;
	logic       prescale_raw;
	logic       timer_tick;
	logic       match;
	logic       match_tick;
	assign prescale_last = 7'((8'h01 << prescale_field) - 8'h01);
	assign prescale_raw  = run && clk_tick && !frozen && (prescale_count_reg == prescale_last);
	// Gated by run so a pending synchronised tick cannot count after a stop
	assign timer_tick    = run && (prescaler_sync_enable
		? ((prescale_raw || prescale_pending_reg) && instr_tick) : prescale_raw);
	assign match         = (count_register == period_buffer_reg);
	assign match_tick    = timer_tick && match;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prescale_count_reg   <= 7'h00;
			prescale_pending_reg <= 1'b0;
		end
		else if (!on_reg || wr_control)
		begin
			prescale_count_reg   <= 7'h00;
			prescale_pending_reg <= 1'b0;
		end
		else
		begin
			if (run && clk_tick && !frozen)
				prescale_count_reg <= prescale_raw ? 7'h00 : prescale_count_reg + 7'h01;
			prescale_pending_reg <= (prescale_raw || prescale_pending_reg) && !instr_tick;
		end
	end

	// ****************************************************************
	// Count and period buffer
	// ****************************************************************
	logic ext_reset_event;
	assign ext_reset_event = at_reset_level && !held_prev_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count_register <= REG_RESET;
		else if (wr_count)
			count_register <= apb_req.pwdata[7:0];
		else if (level_mode && (!on_eff || at_reset_level))
			count_register <= REG_RESET;
		else if (timer_tick)
			count_register <= match ? REG_RESET : count_register + 8'h01;
	end
	assign count_value = count_register;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			period_buffer_reg <= REG_RESET;
		else if (wr_count || wr_control || match_tick || ext_reset_event)
			period_buffer_reg <= period_register;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			period_register <= REG_RESET;
		else if (wr_period)
			period_register <= apb_req.pwdata[7:0];
	end

	// ****************************************************************
	// Control registers
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			on_reg          <= 1'b0;
			prescale_field  <= 3'h0;
			postscale_field <= 4'h0;
		end
		else if (wr_control)
		begin
			on_reg          <= apb_req.pwdata[ON_BIT]; // Software set wins over a same-cycle clear
			prescale_field  <= apb_req.pwdata[6:4];
			postscale_field <= apb_req.pwdata[3:0];
		end
		else if (level_mode && match_tick)
			on_reg <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clock_select_reg   <= 4'h0;
			limit_control_reg  <= REG_RESET;
			reset_source_field <= 5'h00;
		end
		else
		begin
			if (wr_clock)
				clock_select_reg <= apb_req.pwdata[3:0];
			if (wr_limit)
				limit_control_reg <= apb_req.pwdata[7:0]; // relies on software here
			if (wr_rsel)
				reset_source_field <= apb_req.pwdata[4:0];
		end
	end

	// ****************************************************************
	// Postscaler and PWM start
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			postscale_count_reg <= 4'h0;
			postscaled_pulse    <= 1'b0;
		end
		else if (!on_reg)
		begin
			postscale_count_reg <= 4'h0;
			postscaled_pulse    <= 1'b0;
		end
		else
		begin
			postscaled_pulse <= match_tick && (postscale_count_reg == postscale_field);
			if (match_tick)
				postscale_count_reg <= (postscale_count_reg == postscale_field) ? 4'h0
					: postscale_count_reg + 4'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			run_prev_reg    <= 1'b0;
			held_prev_reg   <= 1'b0;
			pwm_start_pulse <= 1'b0;
		end
		else
		begin
			run_prev_reg    <= run;
			held_prev_reg   <= at_reset_level;
			pwm_start_pulse <= level_mode && run && !run_prev_reg;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	sequence s_level_match;
		level_mode && match_tick && !wr_control;
	endsequence

	sequence s_start;
		level_mode && run && !run_prev_reg;
	endsequence

	match_clears_on_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_level_match |=> !on_reg && count_register == 8'h00)
		else $error("Match did not clear enable and count");

	held_in_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
		at_reset_level && !wr_count |=> count_register == 8'h00)
		else $error("Count not held while at reset level");

	start_needs_both_a: assert property (@(posedge pclk) disable iff (!presetn)
		level_mode && timer_tick |-> on_eff && !at_reset_level)
		else $error("Level mode counted without both start conditions");

	pwm_on_start_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_start |=> pwm_start_pulse ##1 !pwm_start_pulse)
		else $error("PWM start pulse missing at timer start");

	buffer_on_count_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_count |=> period_buffer_reg == $past(period_register))
		else $error("Period buffer not loaded on count write");

	sleep_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
		frozen && !wr_count && !at_reset_level && on_eff |=> $stable(count_register))
		else $error("Count moved while frozen in Sleep");

	wrap_to_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		match_tick && !wr_count && !(level_mode && at_reset_level) |=> count_register == 8'h00)
		else $error("Count did not wrap at period match");

	stop_keeps_count_a: assert property (@(posedge pclk) disable iff (!presetn)
		!level_mode && !on_eff && !wr_count |=> $stable(count_register))
		else $error("Stopped count changed");

	prescale_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
		prescale_count_reg <= prescale_last || wr_control || $changed(prescale_field))
		else $error("Prescaler count beyond division");

	rsel_upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		ready_reg && addr_is(apb_req.paddr, RESET_SOURCE_ADDR) |-> prdata[7:5] == 3'h0)
		else $error("Reset source upper bits not zero");

	apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup_phase |=> pready)
		else $error("APB access not answered in one cycle");

endmodule

// ### bench/source_model.sv
// ****
// Clock and reset sources seen by the timer
// ****
module source_model
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        sleep_active,
	input  wire logic        ext_level,
	input  wire logic [2:0]  osc_keep_running,
	output logic      [10:0] clock_sources,
	output logic      [17:0] reset_sources
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [2:0] div_reg;
	logic [2:0] osc_on;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_reg <= 3'h0;
		else
			div_reg <= div_reg + 3'h1;
	end

	// Internal oscillators die in Sleep unless the timer holds them
	assign osc_on = sleep_active ? osc_keep_running : 3'h7;
	assign clock_sources = {{5{div_reg[1]}}, div_reg[1] & osc_on[1], div_reg[2] & osc_on[0],
		div_reg[1] & osc_on[2], 2'h0, div_reg[1]};
	assign reset_sources = {18{ext_level}};
endmodule

// ### bench/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import timer_pkg::*;

	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] r; logic e;} row_s;

	logic                 pclk = 1'b0;
	logic                 presetn = 1'b0;
	logic                 sleep_active = 1'b0;
	logic                 ext_level = 1'b0;
	apb_req_s             apb_req = '0;
	logic [31:0]          prdata;
	logic                 pready;
	logic                 pslverr;
	logic [10:0]          clock_sources;
	logic [17:0]          reset_sources;
	logic [7:0]           count_value;
	logic                 pwm_start_pulse;
	logic                 postscaled_pulse;
	logic [2:0]           osc_keep_running;
	logic [31:0]          rd;
	logic                 err;
	logic [7:0]           c;
	logic [7:0]           top;
	int                   errors = 0;
	int                   comparisons = 0;
	int                   lat;
	row_s                 rows [7] = '{
		'{CLOCK_SELECT_ADDR, 32'hFF, 32'h0F, 1'b0},
		'{RESET_SOURCE_ADDR, 32'hFF, 32'h1F, 1'b0},
		'{LIMIT_CONTROL_ADDR, 32'h5A, 32'h5A, 1'b0},
		'{PERIOD_ADDR, 32'hA5, 32'hA5, 1'b0},
		'{CONTROL_ADDR, 32'h7F, 32'h7F, 1'b0},
		'{COUNT_ADDR, 32'h33, 32'h33, 1'b0},
		'{8'h18, 32'hFF, 32'h00, 1'b1}};

	always #12.5 pclk = ~pclk;

	hw_limit_period_timer hw_limit_period_timer_i (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .clock_sources(clock_sources),
		.reset_sources(reset_sources), .sleep_active(sleep_active), .count_value(count_value),
		.pwm_start_pulse(pwm_start_pulse), .postscaled_pulse(postscaled_pulse),
		.osc_keep_running(osc_keep_running));

	source_model source_model_i (.pclk(pclk), .presetn(presetn), .sleep_active(sleep_active),
		.ext_level(ext_level), .osc_keep_running(osc_keep_running), .clock_sources(clock_sources),
		.reset_sources(reset_sources));

	// ****
	// Shared tasks
	// ****
	task give_verdict;
		if (errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		for (n = 0; n < 20; n++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (n == 20)
		begin
			errors++;
			give_verdict();
		end
		else
		begin
			rd = prdata;
			err = pslverr;
			apb_req <= '0;
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask

	task hold(input int n, input logic [7:0] exp);
		repeat (n)
		begin
			@(negedge pclk);
			chk("count held", exp, count_value);
		end
	endtask

	// Cycles between two events: postscaled pulses, or count changes
	task gap(input bit sel, input int exp);
		int n;
		int k;
		n = 0;
		k = 0;
		c = count_value;
		for (int i = 0; i < 600 && k < 2; i++)
		begin
			@(negedge pclk);
			n++;
			if (sel ? count_value !== c : postscaled_pulse === 1'b1)
			begin
				k++;
				if (k == 2)
					chk("event gap", exp, n);
				n = 0;
			end
			c = count_value;
		end
		if (k < 2)
		begin
			errors++;
			give_verdict();
		end
	endtask

	task wait_pwm;
		for (int i = 0; i < 12; i++)
		begin
			@(negedge pclk);
			if (pwm_start_pulse === 1'b1)
				break;
		end
		chk("pwm start", 1, pwm_start_pulse);
	endtask

	initial
	begin
		repeat (100000) @(posedge pclk);
		errors++;
		give_verdict();
	end

	// ****
	// Main sequence
	// ****
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i])
		begin
			apb(1'b0, rows[i].a, 32'h0);
			chk("reset value", 32'h0, rd);
			apb(1'b1, rows[i].a, rows[i].d);
			apb(1'b0, rows[i].a, 32'h0);
			chk("readback", rows[i].r, rd);
			chk("pslverr", rows[i].e, err);
		end
		wr(CLOCK_SELECT_ADDR, 8'h02);
		wr(LIMIT_CONTROL_ADDR, 8'h00);
		wr(PERIOD_ADDR, 8'h02);
		wr(CONTROL_ADDR, 8'h83);
		gap(1'b0, 12);
		wr(CONTROL_ADDR, 8'hA0);
		gap(1'b1, 4);
		wr(CONTROL_ADDR, 8'h20);
		repeat (2) @(negedge pclk);
		hold(10, count_value);
		// Slow prescale so the count sits well below the new period
		wr(PERIOD_ADDR, 8'd200);
		wr(CONTROL_ADDR, 8'hF0);
		wr(COUNT_ADDR, 8'h00);
		wr(PERIOD_ADDR, 8'h03);
		top = 8'h0;
		repeat (1500) @(negedge pclk) if (count_value > top) top = count_value;
		chk("count past visible period", 1, top >= 8'd5);
		wr(COUNT_ADDR, 8'h00);
		@(negedge pclk);
		top = 8'h0;
		repeat (1200) @(negedge pclk) if (count_value > top) top = count_value;
		chk("count peak", 8'h03, top);
		wr(PERIOD_ADDR, 8'hFF);
		wr(CONTROL_ADDR, 8'h80);
		for (int cs = 0; cs < 12; cs++)
		begin
			wr(CLOCK_SELECT_ADDR, cs[7:0]);
			repeat (3) @(negedge pclk);
			c = count_value;
			repeat (40) @(negedge pclk);
			chk("count moves", cs != 11, count_value !== c);
			chk("osc hold", cs == 3 ? 4 : cs == 4 ? 1 : cs == 5 ? 2 : 0, osc_keep_running);
		end
		wr(CLOCK_SELECT_ADDR, 8'h03);
		// Polarity stays 0 through every limit write while running
		wr(LIMIT_CONTROL_ADDR, 8'h80);
		@(posedge pclk);
		sleep_active <= 1'b1;
		repeat (5) @(negedge pclk);
		hold(40, count_value);
		wr(LIMIT_CONTROL_ADDR, 8'h00);
		repeat (5) @(negedge pclk);
		c = count_value;
		repeat (40) @(negedge pclk);
		chk("count in sleep", 1, count_value !== c);
		@(posedge pclk);
		sleep_active <= 1'b0;
		for (int lvl = 0; lvl < 2; lvl++)
		begin
			@(posedge pclk);
			ext_level <= lvl[0];
			wr(CLOCK_SELECT_ADDR, 8'h02);
			wr(PERIOD_ADDR, 8'h05);
			wr(RESET_SOURCE_ADDR, 8'h00);
			wr(LIMIT_CONTROL_ADDR, MODE_LVL_OS_LOW | lvl[4:0]);
			wr(CONTROL_ADDR, 8'h80);
			hold(20, 8'h00);
			@(posedge pclk);
			ext_level <= ~lvl[0];
			wait_pwm();
			repeat (30) @(negedge pclk);
			apb(1'b0, CONTROL_ADDR, 32'h0);
			chk("enable after match", 32'h0, rd);
			hold(20, 8'h00);
			wr(CONTROL_ADDR, 8'h80);
			wait_pwm();
		end
		// ****
		// Polarity and enable synchronisation, changed only while stopped
		// ****
		for (int pol = 0; pol < 2; pol++)
		begin
			wr(CONTROL_ADDR, 8'h00);
			wr(CLOCK_SELECT_ADDR, 8'h00);
			wr(LIMIT_CONTROL_ADDR, pol[0] ? 8'h40 : 8'h00);
			wr(CONTROL_ADDR, 8'h80);
			c = count_value;
			for (int i = 0; i < 20 && count_value === c; i++)
				@(negedge pclk);
			chk("pin tick seen", 1, count_value !== c);
			chk("pin level at tick", !pol[0], clock_sources[0]);
		end
		for (int s = 0; s < 2; s++)
		begin
			wr(CONTROL_ADDR, 8'h00);
			wr(CLOCK_SELECT_ADDR, 8'h02);
			wr(LIMIT_CONTROL_ADDR, s[0] ? 8'h20 : 8'h00);
			wr(CONTROL_ADDR, 8'h80);
			lat = 0;
			c = count_value;
			for (int i = 0; i < 20 && count_value === c; i++)
			begin
				@(negedge pclk);
				lat++;
			end
			chk("start latency", s[0] ? 4 : 2, lat);
		end
		// Mid-run reset brings back every register and output
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("outputs in reset", 0, {count_value, pwm_start_pulse, postscaled_pulse, osc_keep_running});
		presetn <= 1'b1;
		apb(1'b0, CONTROL_ADDR, 32'h0);
		chk("control after reset", 32'h0, rd);
		apb(1'b0, LIMIT_CONTROL_ADDR, 32'h0);
		chk("limit after reset", 32'h0, rd);
		give_verdict();
	end
endmodule
